// ### design/cfg_port_pkg.sv
// constants for the serial configuration port
package cfg_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 8;
  localparam int DATA_BITS = 8;
  localparam logic [7:0] ADDR_SOFT_RESET_AND_READBACK_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OUTPUT_SWING_CTRL = 8'h01;
  localparam logic [7:0] ADDR_PERFORMANCE_TUNING = 8'h03;
  localparam logic [7:0] ADDR_CHAN_A_GAIN_AND_PATTERN = 8'h25;
  localparam logic [7:0] ADDR_OUTPUT_NUMBER_FORMAT = 8'h29;
  localparam logic [7:0] ADDR_CHAN_B_GAIN_AND_PATTERN = 8'h2B;
  localparam logic [7:0] ADDR_OFFSET_LOOP_ENABLE = 8'h3D;
  localparam logic [7:0] ADDR_FIXED_PATTERN_UPPER = 8'h3F;
  localparam logic [7:0] ADDR_FIXED_PATTERN_LOWER = 8'h40;
  localparam logic [7:0] ADDR_OUTPUT_INTERFACE_CTRL = 8'h41;
  localparam logic [7:0] ADDR_OUTPUT_CLOCK_EDGE_CTRL = 8'h42;
  localparam logic [7:0] ADDR_HF_TUNING_B = 8'h4A;
  localparam logic [7:0] ADDR_HF_TUNING_A = 8'h58;
  localparam logic [7:0] ADDR_HS_TUNING_1 = 8'h02;
  localparam logic [7:0] ADDR_HS_TUNING_2 = 8'hD5;
  localparam logic [7:0] ADDR_HS_TUNING_3 = 8'hD7;
  localparam logic [7:0] ADDR_HS_TUNING_4 = 8'hDB;
  localparam logic [7:0] ADDR_LOW_SPEED_EN = 8'hEF;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h45;
  localparam int NUM_REGS = 18;
  localparam logic [7:0] REG_RESET_VALUE = 8'h00;
  localparam int SOFT_RESET_BIT = 1;
  localparam int READBACK_EN_BIT = 0;
  localparam int FORMAT_MSB = 4;
  localparam int FORMAT_LSB = 3;
  localparam int IFACE_MSB = 7;
  localparam int IFACE_LSB = 6;
  localparam int LOW_SPEED_BIT = 4;
  localparam logic [1:0] CODE_CMOS = 2'h3;
  localparam logic [1:0] FORMAT_OFFSET_BIN = 2'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int RESET_PULSE_NS = 10;
  localparam int RESET_PULSE_CYC = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // select-pin levels as seen by the four-level comparator
  localparam logic [1:0] SEL_LVL_GND = 2'h0;
  localparam logic [1:0] SEL_LVL_3_8 = 2'h1;
  localparam logic [1:0] SEL_LVL_5_8 = 2'h2;
  localparam logic [1:0] SEL_LVL_FULL = 2'h3;
  typedef enum logic [2:0] {
    PWR_NORMAL, PWR_GLOBAL_DOWN, PWR_A_STANDBY, PWR_MUX_ON_B, PWR_UNAVAILABLE
  } power_mode_e;
endpackage : cfg_port_pkg

// ### design/shift_link_if.sv
// shift events passed from the edge finder to the main block
`timescale 1ns/10ps
`default_nettype none
interface shift_link_if;
  logic select_active;
  logic fall_edge;
  logic sample_bit;
  logic clk_level;
  modport src (output select_active, output fall_edge, output sample_bit, output clk_level);
  modport dst (input select_active, input fall_edge, input sample_bit, input clk_level);
endinterface : shift_link_if
`default_nettype wire

// ### design/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin,
  input wire logic init,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  logic held;

  // chain stores the pin relative to its idle level, so every stage resets to zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin ^ init;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // level moves only once the second and third stages agree
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      held <= 1'b0;
    end else if (s2 == s3) begin
      held <= s3;
    end
  end

  // idle level restored at the output, so no false edge follows reset
  assign level = held ^ init;
endmodule : pin_sync
`default_nettype wire

// ### design/shift_edge_finder.sv
// synchronises select, shift clock and data, and finds falling edges
`timescale 1ns/10ps
`default_nettype none
module shift_edge_finder (
  input wire logic clock,
  input wire logic rst,
  input wire logic serial_select_n,
  input wire logic shift_clk,
  input wire logic serial_in_line,
  shift_link_if.src link
);
  logic sel_n_s;
  logic clk_s;
  logic din_s;
  logic clk_prev;

  pin_sync u_sel (.clock(clock), .rst(rst), .pin(serial_select_n), .init(1'b1), .level(sel_n_s));
  pin_sync u_clk (.clock(clock), .rst(rst), .pin(shift_clk), .init(1'b0), .level(clk_s));
  pin_sync u_din (.clock(clock), .rst(rst), .pin(serial_in_line), .init(1'b0), .level(din_s));

  // previous filtered shift-clock level for edge detection
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= clk_s;
    end
  end

  assign link.select_active = ~sel_n_s;
  assign link.fall_edge = clk_prev & ~clk_s;
  assign link.sample_bit = din_s;
  assign link.clk_level = clk_s;
endmodule : shift_edge_finder
`default_nettype wire

// ### design/adc_config_serial_port.sv
// serial configuration port: register file, readback and pin-strap decode
// Operation
// - shift only while select is low
// - sample data on shift clock falling edge
// - commit word every 16th falling edge
// - discard trailing partial word
// - several words per select period
// - eight address bits then eight data
// - reset pin pulse restores defaults
// - soft reset bit restores, self-clears
// - readback enable blocks register writes; the readback enable bit itself stays writable
// - readback drives data MSB first
// - output released when readback disabled
// - reset tied high selects pin-strap mode
// - strap shift clock sets low-speed mode
// - four-level select sets format, interface
// - power-mode pins select power mode
// - reset low: pins plus serial access
// - registers zero after reset, multi-field writes
// - interface code 11 only is CMOS
`timescale 1ns/10ps
`default_nettype none
module adc_config_serial_port
  import cfg_port_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_pin,
  input wire logic serial_select_n,
  input wire logic shift_clk,
  input wire logic serial_in_line,
  input wire logic [1:0] select_level,
  input wire logic power_mode_pin_1,
  input wire logic power_mode_pin_2,
  input wire logic power_mode_pin_3,
  output logic serial_out_line,
  output logic serial_out_oe_n,
  output logic strap_mode,
  output logic low_speed_en,
  output logic offset_binary,
  output logic cmos_output,
  output power_mode_e power_mode,
  output logic [7:0] perf_tuning_bits,
  output logic hf_input_tuning_a,
  output logic hf_input_tuning_b
);
  // register address table in index order
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{
    ADDR_SOFT_RESET_AND_READBACK_CTRL, ADDR_OUTPUT_SWING_CTRL, ADDR_PERFORMANCE_TUNING,
    ADDR_CHAN_A_GAIN_AND_PATTERN, ADDR_OUTPUT_NUMBER_FORMAT, ADDR_CHAN_B_GAIN_AND_PATTERN,
    ADDR_OFFSET_LOOP_ENABLE, ADDR_FIXED_PATTERN_UPPER, ADDR_FIXED_PATTERN_LOWER,
    ADDR_OUTPUT_INTERFACE_CTRL, ADDR_OUTPUT_CLOCK_EDGE_CTRL, ADDR_HF_TUNING_B,
    ADDR_HF_TUNING_A, ADDR_HS_TUNING_1, ADDR_HS_TUNING_2, ADDR_HS_TUNING_3,
    ADDR_HS_TUNING_4, ADDR_LOW_SPEED_EN
  };
  localparam int IDX_CTRL = 0;
  localparam int IDX_PERF = 2;
  localparam int IDX_FORMAT = 4;
  localparam int IDX_IFACE = 9;
  localparam int IDX_HF_B = 11;
  localparam int IDX_HF_A = 12;
  localparam int IDX_LOW_SPEED = 17;

  shift_link_if link ();

  logic reset_pin_s;
  logic [7:0] regs [NUM_REGS];
  logic [15:0] shift_reg;
  logic [3:0] bit_count;
  logic soft_reset_pending;
  logic [7:0] read_shift;
  logic reading;
  logic [3:0] read_count;
  logic [2:0] rst_pulse_count;
  logic reset_seen_low;
  logic [15:0] next_word;
  logic [7:0] rb_value;
  logic word_done;
  logic [1:0] sel_s;
  logic pm1_s;
  logic pm2_s;
  logic pm3_s;

  // address decode used by write and read paths
  function automatic int unsigned addr_index(input logic [7:0] addr);
    int unsigned idx;
    idx = NUM_REGS;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (REG_ADDR[i] == addr) begin
        idx = i;
      end
    end
    return idx;
  endfunction : addr_index

  shift_edge_finder u_edges (
    .clock(clock),
    .rst(rst),
    .serial_select_n(serial_select_n),
    .shift_clk(shift_clk),
    .serial_in_line(serial_in_line),
    .link(link.src)
  );

  pin_sync u_rstpin (.clock(clock), .rst(rst), .pin(reset_pin), .init(1'b0), .level(reset_pin_s));
  pin_sync u_sel0 (.clock(clock), .rst(rst), .pin(select_level[0]), .init(1'b0), .level(sel_s[0]));
  pin_sync u_sel1 (.clock(clock), .rst(rst), .pin(select_level[1]), .init(1'b0), .level(sel_s[1]));
  pin_sync u_pm1 (.clock(clock), .rst(rst), .pin(power_mode_pin_1), .init(1'b0), .level(pm1_s));
  pin_sync u_pm2 (.clock(clock), .rst(rst), .pin(power_mode_pin_2), .init(1'b0), .level(pm2_s));
  pin_sync u_pm3 (.clock(clock), .rst(rst), .pin(power_mode_pin_3), .init(1'b0), .level(pm3_s));

  // each shift-clock phase must last two system clocks to be seen
  // next shift word, MSB first, and completion of 16 bits
  assign next_word = {shift_reg[14:0], link.sample_bit};
  assign word_done = link.fall_edge && link.select_active && (bit_count == 4'hF);

  // bit counter restarts whenever select goes high, dropping partial words
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_count <= 4'h0;
      shift_reg <= 16'h0000;
    end else if (!link.select_active) begin
      bit_count <= 4'h0;
    end else if (link.fall_edge) begin
      shift_reg <= next_word;
      bit_count <= bit_count + 4'h1;
    end
  end

  // reset pin pulse length; a long high level means pin-strap mode
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rst_pulse_count <= 3'h0;
      reset_seen_low <= 1'b0;
      strap_mode <= 1'b0;
    end else begin
      if (reset_pin_s) begin
        if (rst_pulse_count != 3'h7) begin
          rst_pulse_count <= rst_pulse_count + 3'h1;
        end
      end else begin
        rst_pulse_count <= 3'h0;
        reset_seen_low <= 1'b1;
      end
      strap_mode <= reset_pin_s && (!reset_seen_low || rst_pulse_count == 3'h7);
    end
  end

  // register file with pin and soft reset, write blocking in readback
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET_VALUE;
      end
      soft_reset_pending <= 1'b0;
    end else if ((reset_pin_s && rst_pulse_count >= 3'(RESET_PULSE_CYC)) || soft_reset_pending) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET_VALUE;
      end
      soft_reset_pending <= 1'b0;
    end else if (word_done && !regs[IDX_CTRL][READBACK_EN_BIT]) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        if (addr_index(next_word[15:8]) == i) begin
          regs[i] <= next_word[7:0];
        end
      end
      if (next_word[15:8] == ADDR_SOFT_RESET_AND_READBACK_CTRL) begin
        soft_reset_pending <= next_word[SOFT_RESET_BIT];
      end
    end else if (word_done && next_word[15:8] == ADDR_SOFT_RESET_AND_READBACK_CTRL) begin
      // readback can still be switched off through its own register
      regs[IDX_CTRL][READBACK_EN_BIT] <= next_word[READBACK_EN_BIT];
    end
  end

  // value of the register named by the address byte just shifted in
  always_comb begin
    rb_value = 8'h00;
    if (addr_index(next_word[7:0]) < NUM_REGS) begin
      rb_value = regs[addr_index(next_word[7:0])];
    end
  end

  // readback: each data bit goes out right after a detected fall, MSB first,
  // so it is already steady when the host samples at the next falling edge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      read_shift <= 8'h00;
      reading <= 1'b0;
      read_count <= 4'h0;
      serial_out_line <= 1'b0;
    end else if (!link.select_active || !regs[IDX_CTRL][READBACK_EN_BIT]) begin
      reading <= 1'b0;
      read_count <= 4'h0;
      serial_out_line <= 1'b0;
    end else if (link.fall_edge) begin
      read_count <= read_count + 4'h1;
      if (read_count == 4'h7) begin
        read_shift <= rb_value;
        serial_out_line <= rb_value[7];
        reading <= 1'b1;
      end else if (reading) begin
        read_shift <= {read_shift[6:0], 1'b0};
        serial_out_line <= read_shift[6];
      end
    end
  end

  // output enable low only while readback is on
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      serial_out_oe_n <= 1'b1;
    end else begin
      serial_out_oe_n <= !regs[IDX_CTRL][READBACK_EN_BIT] || strap_mode;
    end
  end

  // mode outputs from straps or from registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      low_speed_en <= 1'b0;
      offset_binary <= 1'b0;
      cmos_output <= 1'b0;
    end else if (strap_mode) begin
      low_speed_en <= link.clk_level;
      offset_binary <= (sel_s == SEL_LVL_3_8) || (sel_s == SEL_LVL_5_8);
      cmos_output <= (sel_s == SEL_LVL_GND) || (sel_s == SEL_LVL_3_8);
    end else begin
      low_speed_en <= regs[IDX_LOW_SPEED][LOW_SPEED_BIT];
      offset_binary <= regs[IDX_FORMAT][FORMAT_MSB:FORMAT_LSB] == FORMAT_OFFSET_BIN;
      cmos_output <= regs[IDX_IFACE][IFACE_MSB:IFACE_LSB] == CODE_CMOS;
    end
  end

  // power mode from the three pins, in both strap and mixed modes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      power_mode <= PWR_NORMAL;
    end else begin
      case ({pm1_s, pm2_s, pm3_s})
        3'b000: power_mode <= PWR_NORMAL;
        3'b100: power_mode <= PWR_GLOBAL_DOWN;
        3'b101: power_mode <= PWR_A_STANDBY;
        3'b111: power_mode <= PWR_MUX_ON_B;
        default: power_mode <= PWR_UNAVAILABLE;
      endcase
    end
  end

  // tuning register views
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      perf_tuning_bits <= 8'h00;
      hf_input_tuning_a <= 1'b0;
      hf_input_tuning_b <= 1'b0;
    end else begin
      perf_tuning_bits <= regs[IDX_PERF];
      hf_input_tuning_a <= regs[IDX_HF_A][0];
      hf_input_tuning_b <= regs[IDX_HF_B][0];
    end
  end

  // checks
  a_oe_follows_rb: assert property (@(posedge clock) disable iff (rst)
    !regs[IDX_CTRL][READBACK_EN_BIT] && !strap_mode |=> serial_out_oe_n)
    else $error("readback off but output enabled");
  a_partial_drop: assert property (@(posedge clock) disable iff (rst)
    !link.select_active |=> bit_count == 4'h0)
    else $error("bit count kept after select high");
  a_count_hold: assert property (@(posedge clock) disable iff (rst)
    link.select_active && !link.fall_edge |=> $stable(bit_count))
    else $error("bit count moved without edge");
  a_soft_clear: assert property (@(posedge clock) disable iff (rst)
    soft_reset_pending |=> !soft_reset_pending && regs[IDX_CTRL] == REG_RESET_VALUE)
    else $error("soft reset not applied");
  a_block_write: assert property (@(posedge clock) disable iff (rst)
    word_done && regs[IDX_CTRL][READBACK_EN_BIT] && !reset_pin_s && !soft_reset_pending &&
    next_word[15:8] == ADDR_PERFORMANCE_TUNING |=> $stable(regs[IDX_PERF]))
    else $error("write landed during readback");
  a_commit_write: assert property (@(posedge clock) disable iff (rst)
    word_done && !regs[IDX_CTRL][READBACK_EN_BIT] && !reset_pin_s && !soft_reset_pending &&
    next_word[15:8] == ADDR_PERFORMANCE_TUNING |=> regs[IDX_PERF] == $past(next_word[7:0]))
    else $error("word not committed");
  a_iface_code: assert property (@(posedge clock) disable iff (rst)
    !strap_mode |=> cmos_output == ($past(regs[IDX_IFACE][7:6]) == 2'h3))
    else $error("interface decode wrong");
  a_power_down: assert property (@(posedge clock) disable iff (rst)
    {pm1_s, pm2_s, pm3_s} == 3'b100 |=> power_mode == PWR_GLOBAL_DOWN)
    else $error("global power-down not selected");
  a_mux_mode: assert property (@(posedge clock) disable iff (rst)
    {pm1_s, pm2_s, pm3_s} == 3'b111 |=> power_mode == PWR_MUX_ON_B)
    else $error("mux mode not selected");
  a_unavail_code: assert property (@(posedge clock) disable iff (rst)
    {pm1_s, pm2_s, pm3_s} == 3'b010 |=> power_mode == PWR_UNAVAILABLE)
    else $error("unavailable code accepted");
  // shift and write path
  a_shift_msb: assert property (@(posedge clock) disable iff (rst)
    link.select_active && link.fall_edge |=> shift_reg == $past(next_word))
    else $error("bit not shifted in msb first");
  a_commit_second: assert property (@(posedge clock) disable iff (rst)
    word_done && !regs[IDX_CTRL][READBACK_EN_BIT] && !reset_pin_s && !soft_reset_pending &&
    next_word[15:8] == ADDR_HF_TUNING_A |=> regs[IDX_HF_A] == $past(next_word[7:0]))
    else $error("second word not committed");
  a_pin_reset: assert property (@(posedge clock) disable iff (rst)
    reset_pin_s && rst_pulse_count >= 3'(RESET_PULSE_CYC) |=> regs[IDX_PERF] == 8'h00)
    else $error("reset pin did not clear registers");
  // readback output
  a_rb_first_bit: assert property (@(posedge clock) disable iff (rst)
    link.select_active && regs[IDX_CTRL][READBACK_EN_BIT] && link.fall_edge &&
    read_count == 4'h7 |=> serial_out_line == $past(rb_value[7]))
    else $error("first readback bit wrong");
  a_rb_next_bit: assert property (@(posedge clock) disable iff (rst)
    link.select_active && regs[IDX_CTRL][READBACK_EN_BIT] && link.fall_edge && reading &&
    read_count != 4'h7 |=> serial_out_line == $past(read_shift[6]))
    else $error("readback bit out of order");
  // pin-strap decode
  a_strap_entry: assert property (@(posedge clock) disable iff (rst)
    reset_pin_s && rst_pulse_count == 3'h7 |=> strap_mode)
    else $error("held reset pin did not select strap mode");
  a_strap_speed: assert property (@(posedge clock) disable iff (rst)
    strap_mode |=> low_speed_en == $past(link.clk_level))
    else $error("strap low-speed level wrong");
  a_strap_ground: assert property (@(posedge clock) disable iff (rst)
    strap_mode && sel_s == SEL_LVL_GND |=> cmos_output && !offset_binary)
    else $error("ground level decode wrong");
  a_strap_low_mid: assert property (@(posedge clock) disable iff (rst)
    strap_mode && sel_s == SEL_LVL_3_8 |=> cmos_output && offset_binary)
    else $error("lower middle level decode wrong");
  a_strap_high_mid: assert property (@(posedge clock) disable iff (rst)
    strap_mode && sel_s == SEL_LVL_5_8 |=> !cmos_output && offset_binary)
    else $error("upper middle level decode wrong");
  a_strap_full: assert property (@(posedge clock) disable iff (rst)
    strap_mode && sel_s == SEL_LVL_FULL |=> !cmos_output && !offset_binary)
    else $error("full level decode wrong");
  // main scenarios
  c_word: cover property (@(posedge clock) disable iff (rst) word_done);
  c_readback: cover property (@(posedge clock) disable iff (rst) reading && !serial_out_oe_n);
  c_strap: cover property (@(posedge clock) disable iff (rst) strap_mode);
  c_soft: cover property (@(posedge clock) disable iff (rst) soft_reset_pending);
  c_blocked: cover property (@(posedge clock) disable iff (rst)
    word_done && regs[IDX_CTRL][READBACK_EN_BIT]);
endmodule : adc_config_serial_port
`default_nettype wire

// ### test/host_model.sv
// host controller model driving the serial configuration pins
`timescale 1ns/10ps
`default_nettype none
module host_model #(
  parameter int HALF_NS = 200
) (
  input wire logic clock,
  input wire logic sdo_wire,
  output logic serial_select_n,
  output logic shift_clk,
  output logic serial_in_line,
  output logic reset_pin
);
  logic [7:0] rd_byte;

  // idle pins: select high, shift clock parked low, reset pin low
  initial begin
    serial_select_n = 1'b1;
    shift_clk = 1'b0;
    serial_in_line = 1'b0;
    reset_pin = 1'b0;
    rd_byte = 8'h00;
  end

  // one frame of n bits, msb first; sel_level high shifts with select idle
  task automatic frame(input logic [31:0] bits, input int n, input logic sel_level);
    @(posedge clock);
    #1;  // pins change just after the system clock edge
    serial_select_n = sel_level;
    #(HALF_NS);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_line = bits[i];
      shift_clk = 1'b1;
      #(HALF_NS);
      rd_byte = {rd_byte[6:0], sdo_wire};
      shift_clk = 1'b0;
      #(HALF_NS);
    end
    #(HALF_NS);
    serial_select_n = 1'b1;
    serial_in_line = ~serial_in_line;  // released line must not look held
    repeat (4) @(posedge clock);
    #1;
  endtask : frame

  // single register write
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    frame({16'h0000, addr, data}, 16, 1'b0);
  endtask : write_reg

  // two writes inside one select-low period
  task automatic write_pair(input logic [15:0] w1, input logic [15:0] w2);
    frame({w1, w2}, 32, 1'b0);
  endtask : write_pair

  // readback cycle; data bits keep readback on if taken as a control write
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
    frame({16'h0000, addr, 8'h01}, 16, 1'b0);
    data = rd_byte;
  endtask : read_reg

  // short high pulse on the reset pin, then back low
  task automatic pulse_reset(input int cycles);
    @(posedge clock);
    #1;
    reset_pin = 1'b1;
    repeat (cycles) @(posedge clock);
    #1;
    reset_pin = 1'b0;
    repeat (6) @(posedge clock);
    #1;
  endtask : pulse_reset

  // static levels for pin-strap use
  task automatic strap_pins(input logic rst_level, input logic sclk_level);
    @(posedge clock);
    #1;
    reset_pin = rst_level;
    shift_clk = sclk_level;
  endtask : strap_pins
endmodule : host_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the serial configuration port
`timescale 1ns/10ps
`default_nettype none
module testbench
  import cfg_port_pkg::*;
;
  logic clock;
  logic rst;
  logic serial_select_n;
  logic shift_clk;
  logic serial_in_line;
  logic reset_pin;
  logic [1:0] select_level;
  logic [2:0] pm_pins;
  logic serial_out_line;
  logic serial_out_oe_n;
  logic strap_mode;
  logic low_speed_en;
  logic offset_binary;
  logic cmos_output;
  power_mode_e power_mode;
  logic [7:0] perf_tuning_bits;
  logic hf_input_tuning_a;
  logic hf_input_tuning_b;
  wire sdo_wire;
  logic [7:0] rd;
  int n_mismatch;
  int cmp_count;
  power_mode_e pm_tab [8] = '{PWR_NORMAL, PWR_UNAVAILABLE, PWR_UNAVAILABLE, PWR_UNAVAILABLE,
                              PWR_GLOBAL_DOWN, PWR_A_STANDBY, PWR_UNAVAILABLE, PWR_MUX_ON_B};
  logic [1:0] strap_tab [4] = '{2'b01, 2'b11, 2'b10, 2'b00};

  // readback pin floats whenever the device is not driving it
  assign sdo_wire = serial_out_oe_n ? 1'bz : serial_out_line;

  adc_config_serial_port dut (
    .clock(clock), .rst(rst), .reset_pin(reset_pin), .serial_select_n(serial_select_n),
    .shift_clk(shift_clk), .serial_in_line(serial_in_line), .select_level(select_level),
    .power_mode_pin_1(pm_pins[2]), .power_mode_pin_2(pm_pins[1]),
    .power_mode_pin_3(pm_pins[0]), .serial_out_line(serial_out_line),
    .serial_out_oe_n(serial_out_oe_n), .strap_mode(strap_mode),
    .low_speed_en(low_speed_en), .offset_binary(offset_binary), .cmos_output(cmos_output),
    .power_mode(power_mode), .perf_tuning_bits(perf_tuning_bits),
    .hf_input_tuning_a(hf_input_tuning_a), .hf_input_tuning_b(hf_input_tuning_b)
  );

  host_model host (
    .clock(clock), .sdo_wire(sdo_wire), .serial_select_n(serial_select_n),
    .shift_clk(shift_clk), .serial_in_line(serial_in_line), .reset_pin(reset_pin)
  );

  // 50 ns system clock
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // compares one value and counts the outcome
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // prints counts and verdict, then stops
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // cuts a hung run short
  initial begin
    #3000000;
    n_mismatch++;
    $display("ERROR at %0t ns: run timed out", $time);
    end_of_test();
  end

  // main sequence
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    rst = 1'b1;
    select_level = SEL_LVL_GND;
    pm_pins = 3'b000;
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    check({7'h00, serial_out_oe_n}, 8'h01);
    check(perf_tuning_bits, 8'h00);
    check({6'h00, offset_binary, cmos_output}, 8'h00);
    check({7'h00, strap_mode}, 8'h00);
    host.pulse_reset(3);
    host.write_reg(ADDR_PERFORMANCE_TUNING, 8'h03);
    check(perf_tuning_bits, 8'h03);
    host.write_pair({ADDR_HF_TUNING_B, 8'h01}, {ADDR_HF_TUNING_A, 8'h01});
    check({6'h00, hf_input_tuning_a, hf_input_tuning_b}, 8'h03);
    // full word followed by five stray bits
    host.frame(32'({ADDR_PERFORMANCE_TUNING, 8'hA5, 5'h1F}), 21, 1'b0);
    check(perf_tuning_bits, 8'hA5);
    host.frame(32'({ADDR_PERFORMANCE_TUNING, 4'h6}), 12, 1'b0);
    check(perf_tuning_bits, 8'hA5);
    // shifting with select idle must be ignored
    host.frame(32'({ADDR_PERFORMANCE_TUNING, 8'h3C}), 16, 1'b1);
    check(perf_tuning_bits, 8'hA5);
    // every format and interface code
    for (int c = 0; c < 4; c++) begin
      host.write_pair({ADDR_OUTPUT_NUMBER_FORMAT, 8'(c << 3)},
                      {ADDR_OUTPUT_INTERFACE_CTRL, 8'(c << 6)});
      check({6'h00, offset_binary, cmos_output}, (c == 3) ? 8'h03 : 8'h00);
    end
    host.write_reg(ADDR_LOW_SPEED_EN, 8'h10);
    check({7'h00, low_speed_en}, 8'h01);
    host.write_pair({ADDR_HS_TUNING_1, 8'h40}, {ADDR_HS_TUNING_2, 8'h18});
    host.write_pair({ADDR_HS_TUNING_3, 8'h0C}, {ADDR_HS_TUNING_4, 8'h20});
    // readback, blocked writes, resume
    host.write_reg(ADDR_SOFT_RESET_AND_READBACK_CTRL, 8'h01);
    check({7'h00, serial_out_oe_n}, 8'h00);
    host.read_reg(ADDR_PERFORMANCE_TUNING, rd);
    check(rd, 8'hA5);
    host.write_reg(ADDR_PERFORMANCE_TUNING, 8'h5A);
    check(perf_tuning_bits, 8'hA5);
    host.read_reg(ADDR_HF_TUNING_A, rd);
    check(rd, 8'h01);
    host.read_reg(8'h77, rd);
    check(rd, 8'h00);
    host.read_reg(ADDR_HS_TUNING_4, rd);
    check(rd, 8'h20);
    host.write_reg(ADDR_SOFT_RESET_AND_READBACK_CTRL, 8'h00);
    check({7'h00, serial_out_oe_n}, 8'h01);
    host.write_reg(ADDR_PERFORMANCE_TUNING, 8'h5A);
    check(perf_tuning_bits, 8'h5A);
    // soft reset clears everything and itself
    host.write_reg(ADDR_SOFT_RESET_AND_READBACK_CTRL, 8'h02);
    check(perf_tuning_bits, 8'h00);
    check({5'h00, hf_input_tuning_a, hf_input_tuning_b, low_speed_en}, 8'h00);
    host.write_reg(ADDR_SOFT_RESET_AND_READBACK_CTRL, 8'h01);
    host.read_reg(ADDR_SOFT_RESET_AND_READBACK_CTRL, rd);
    check(rd, 8'h01);
    host.write_reg(ADDR_SOFT_RESET_AND_READBACK_CTRL, 8'h00);
    // all eight power-mode pin codes
    for (int p = 0; p < 8; p++) begin
      @(posedge clock);
      #1 pm_pins = 3'(p);
      repeat (8) @(posedge clock);
      #1;
      check(8'(power_mode), 8'(pm_tab[p]));
    end
    // reset pin held high: pin-strap decode
    host.strap_pins(1'b1, 1'b0);
    repeat (16) @(posedge clock);
    #1;
    check({7'h00, strap_mode}, 8'h01);
    for (int c = 0; c < 4; c++) begin
      host.strap_pins(1'b1, c[0]);
      select_level = 2'(c);
      repeat (8) @(posedge clock);
      #1;
      check({5'h00, low_speed_en, offset_binary, cmos_output}, {5'h00, c[0], strap_tab[c]});
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
